// >>> verilog/tmwb_top.sv
// Wide-mode byte access path, counter, compare/capture word and control register A
//
// Summary of operation
// R01: Width bit set makes counter and compare 16-bit, reached as two byte accesses.
// R02: One 8-bit high-byte latch is shared by every wide register.
// R03: Low-byte write loads latch and written byte into the word in one cycle.
// R04: Low-byte read copies the high byte into the latch as the low byte returns.
// R05: Software writes high then low; reads low then high.
// R06: Compare word reads bypass the latch in output-compare operation.
// R07: Capture word reads go through the latch, low first then high.
// R08: Main code masks interrupts when handlers also touch wide registers.
// R09: Latch holds its value between accesses, so one high write serves many.
// R10: Control A: width, capture enable, filter, edge, bit 3, zeros 2:1, wave.
// R11: Counter high-byte reads in wide mode return the latch, not the live byte.
// R12: Filter changes its output only after four equal samples.
// R13: Selected edge copies counter into capture word, only its low byte in narrow mode, and sets capture flag.
`timescale 1ns/100ps
`include "tmwb_defs.svh"

module tmwb_top
  import tmwb_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // CPU byte bus
  input  wire tmwb_pkg::tmwb_addr_t cpu_addr_i,
  input  wire logic              cpu_wr_i,
  input  wire logic              cpu_rd_i,
  input  wire tmwb_pkg::tmwb_byte_t cpu_wdata_i,
  output tmwb_pkg::tmwb_byte_t   cpu_rdata_o,
  // Timer side
  input  wire logic              count_en_i,
  input  wire logic              capture_src_i,
  input  wire logic              capture_flag_clr_i,
  output logic                   capture_flag_o,
  output tmwb_pkg::tmwb_word_t   counter_o,
  output tmwb_pkg::tmwb_word_t   compare_o,
  output tmwb_pkg::tmwb_byte_t   control_a_o
);
  import tmwb_pkg::*;

  function automatic logic hit(input tmwb_addr_t a, input tmwb_addr_t off);
    hit = (a == off);
  endfunction : hit

  tmwb_byte_t ctrl_q, ctrl_d;
  tmwb_byte_t temp_q, temp_d;
  tmwb_word_t cnt_q, cnt_d;
  tmwb_word_t cmp_q, cmp_d;
  tmwb_byte_t rdata_q, rdata_d;
  logic       flag_q, flag_d;
  logic       filt_prev_q, filt_prev_d;
  logic       filt;
  logic       wide, cap_en, cap_evt;
  tmwb_byte_t cnt_hi, cmp_hi;

  assign wide   = ctrl_q[`TMWB_BIT_WIDTH]; // [R01]
  assign cap_en = ctrl_q[`TMWB_BIT_CAP_EN];
  assign cnt_hi = cnt_q[15:8];
  assign cmp_hi = cmp_q[15:8];

  tmwb_capture_filter u_filter (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .filter_en_i (ctrl_q[`TMWB_BIT_FILTER]),
    .raw_i       (capture_src_i),
    .filt_o      (filt)
  );

  // Edge select: zero picks falling, one picks rising
  assign cap_evt = cap_en && (ctrl_q[`TMWB_BIT_EDGE] ? (filt && !filt_prev_q)
                                                     : (!filt && filt_prev_q)); // [R13]

  always_comb
  begin
    ctrl_d      = ctrl_q;
    temp_d      = temp_q;
    cnt_d       = cnt_q;
    cmp_d       = cmp_q;
    rdata_d     = rdata_q;
    filt_prev_d = filt;
    flag_d      = flag_q;

    // Counting; CPU writes below take priority
    if (count_en_i)
    begin
      if (wide)
      begin
        cnt_d = cnt_q + `TMWB_WORD_ONE;
      end
      else
      begin
        cnt_d[7:0] = cnt_q[7:0] + `TMWB_BYTE_ONE;
      end
    end

    if (cpu_wr_i)
    begin
      unique case (1'b1)
        hit(cpu_addr_i, `TMWB_OFF_CTRL_A):
          ctrl_d = cpu_wdata_i & `TMWB_CTRL_WMASK; // [R10]
        hit(cpu_addr_i, `TMWB_OFF_CNT_LO):
          if (wide)
          begin
            cnt_d = {temp_q, cpu_wdata_i}; // [R03]
          end
          else
          begin
            cnt_d[7:0] = cpu_wdata_i;
          end
        hit(cpu_addr_i, `TMWB_OFF_CNT_HI), hit(cpu_addr_i, `TMWB_OFF_CMP_HI):
          if (wide)
          begin
            temp_d = cpu_wdata_i; // [R02] [R05]
          end
          else if (hit(cpu_addr_i, `TMWB_OFF_CNT_HI))
          begin
            cnt_d[15:8] = cpu_wdata_i;
          end
          else
          begin
            cmp_d[15:8] = cpu_wdata_i;
          end
        hit(cpu_addr_i, `TMWB_OFF_CMP_LO):
          if (wide)
          begin
            cmp_d = {temp_q, cpu_wdata_i}; // [R03] [R09]
          end
          else
          begin
            cmp_d[7:0] = cpu_wdata_i;
          end
        default:
          ;
      endcase
    end
    else if (cpu_rd_i)
    begin
      unique case (1'b1)
        hit(cpu_addr_i, `TMWB_OFF_CTRL_A):
          rdata_d = ctrl_q;
        hit(cpu_addr_i, `TMWB_OFF_CNT_LO):
        begin
          rdata_d = cnt_q[7:0];
          if (wide)
          begin
            temp_d = cnt_hi; // [R04]
          end
        end
        hit(cpu_addr_i, `TMWB_OFF_CNT_HI):
          rdata_d = wide ? temp_q : cnt_hi; // [R11]
        hit(cpu_addr_i, `TMWB_OFF_CMP_LO):
        begin
          rdata_d = cmp_q[7:0];
          if (wide && cap_en)
          begin
            temp_d = cmp_hi; // [R07] [R04]
          end
        end
        hit(cpu_addr_i, `TMWB_OFF_CMP_HI):
          // In output-compare operation the compare holds a CPU-written value, so no latch is needed
          rdata_d = (wide && cap_en) ? temp_q : cmp_hi; // [R06] [R07]
        default:
          rdata_d = `TMWB_BYTE_ZERO;
      endcase
    end

    // Capture overrides a same-cycle CPU write of the compare word
    if (cap_evt)
    begin
      cmp_d = wide ? cnt_q : {cmp_q[15:8], cnt_q[7:0]}; // [R13]
    end

    // Set wins over clear
    if (cap_evt)
    begin
      flag_d = 1'b1; // [R13]
    end
    else if (capture_flag_clr_i)
    begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q      <= `TMWB_CTRL_RESET; // [R10]
      temp_q      <= `TMWB_BYTE_ZERO;
      cnt_q       <= `TMWB_WORD_ZERO;
      cmp_q       <= `TMWB_WORD_ZERO;
      rdata_q     <= `TMWB_BYTE_ZERO;
      flag_q      <= 1'b0;
      filt_prev_q <= 1'b0;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      temp_q      <= temp_d;
      cnt_q       <= cnt_d;
      cmp_q       <= cmp_d;
      rdata_q     <= rdata_d;
      flag_q      <= flag_d;
      filt_prev_q <= filt_prev_d;
    end
  end

  assign cpu_rdata_o    = rdata_q;
  assign capture_flag_o = flag_q;
  assign counter_o      = cnt_q;
  assign compare_o      = cmp_q;
  assign control_a_o    = ctrl_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic wr_cnt_lo, rd_cnt_lo, rd_cnt_hi, rd_cmp_lo, rd_cmp_hi, temp_touch;
  assign wr_cnt_lo  = cpu_wr_i && hit(cpu_addr_i, `TMWB_OFF_CNT_LO) && wide;
  assign rd_cnt_lo  = !cpu_wr_i && cpu_rd_i && hit(cpu_addr_i, `TMWB_OFF_CNT_LO) && wide;
  assign rd_cnt_hi  = !cpu_wr_i && cpu_rd_i && hit(cpu_addr_i, `TMWB_OFF_CNT_HI) && wide;
  assign rd_cmp_lo  = !cpu_wr_i && cpu_rd_i && hit(cpu_addr_i, `TMWB_OFF_CMP_LO) && wide;
  assign rd_cmp_hi  = !cpu_wr_i && cpu_rd_i && hit(cpu_addr_i, `TMWB_OFF_CMP_HI) && wide;
  assign temp_touch = wide && ((cpu_wr_i && (hit(cpu_addr_i, `TMWB_OFF_CNT_HI) || hit(cpu_addr_i, `TMWB_OFF_CMP_HI)))
                               || rd_cnt_lo || rd_cmp_lo);

  property p_wide_write;
    wr_cnt_lo |=> cnt_q == {$past(temp_q), $past(cpu_wdata_i)};
  endproperty
  a_wide_write: assert property (p_wide_write) else $error("wide counter write not atomic"); // [R03]

  property p_low_read;
    rd_cnt_lo |=> (temp_q == $past(cnt_hi)) && (cpu_rdata_o == $past(cnt_q[7:0]));
  endproperty
  a_low_read: assert property (p_low_read) else $error("low read did not latch high byte"); // [R04]

  property p_high_read;
    rd_cnt_hi |=> cpu_rdata_o == $past(temp_q);
  endproperty
  a_high_read: assert property (p_high_read) else $error("high read did not return latch"); // [R11]

  property p_cmp_bypass;
    (rd_cmp_hi && !cap_en) |=> (cpu_rdata_o == $past(cmp_hi)) && $stable(temp_q);
  endproperty
  a_cmp_bypass: assert property (p_cmp_bypass) else $error("compare read used the latch"); // [R06]

  property p_cap_read;
    (rd_cmp_lo && cap_en) ##1 (rd_cmp_hi && cap_en) |=> cpu_rdata_o == $past(cmp_hi, 2);
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capture word read not atomic"); // [R07]

  property p_latch_hold;
    !temp_touch |=> $stable(temp_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without access"); // [R09] [R02]

  property p_ctrl_zero;
    ctrl_q[2:1] == 2'b00;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control bits 2:1 not zero"); // [R10]

  property p_capture;
    (cap_evt && wide) |=> flag_q && (cmp_q == $past(cnt_q));
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not copy counter or set flag"); // [R13]

  c_wide_write: cover property (wr_cnt_lo);
  c_cap_read:   cover property ((rd_cmp_lo && cap_en) ##1 (rd_cmp_hi && cap_en));
  c_capture:    cover property (cap_evt && wide);
endmodule : tmwb_top

// >>> verilog/tmwb_defs.svh
// Register offsets, field positions and reset values of the wide-access timer block
`ifndef TMWB_DEFS_SVH
`define TMWB_DEFS_SVH

`define TMWB_ADDR_W         3
`define TMWB_OFF_CTRL_A     3'h0
`define TMWB_OFF_CNT_LO     3'h1
`define TMWB_OFF_CNT_HI     3'h2
`define TMWB_OFF_CMP_LO     3'h3
`define TMWB_OFF_CMP_HI     3'h4

`define TMWB_BIT_WIDTH      7
`define TMWB_BIT_CAP_EN     6
`define TMWB_BIT_FILTER     5
`define TMWB_BIT_EDGE       4
`define TMWB_BIT_WAVE       0

`define TMWB_CTRL_WMASK     8'hF9
`define TMWB_CTRL_RESET     8'h00
`define TMWB_BYTE_ZERO      8'h00
`define TMWB_WORD_ZERO      16'h0000
`define TMWB_WORD_ONE       16'h0001
`define TMWB_BYTE_ONE       8'h01

`define TMWB_FILT_LEN       4
`define TMWB_FILT_ONES      4'hF
`define TMWB_FILT_ZEROS     4'h0

`endif

// >>> verilog/tmwb_pkg.sv
// Types shared by the wide-access timer block
package tmwb_pkg;
  typedef logic [7:0]  tmwb_byte_t;
  typedef logic [15:0] tmwb_word_t;
  typedef logic [2:0]  tmwb_addr_t;
  typedef logic [3:0]  tmwb_hist_t;
endpackage : tmwb_pkg

// >>> verilog/tmwb_capture_filter.sv
// Capture input noise filter: four equal samples needed to change the output
`timescale 1ns/100ps
`include "tmwb_defs.svh"

module tmwb_capture_filter
  import tmwb_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Control and data
  input  wire logic filter_en_i,
  input  wire logic raw_i,
  output logic      filt_o
);
  import tmwb_pkg::*;

  tmwb_pkg::tmwb_hist_t hist_q;
  tmwb_pkg::tmwb_hist_t hist_d;
  logic                 out_q;
  logic                 out_d;

  always_comb
  begin
    hist_d = {hist_q[2:0], raw_i};
    out_d  = out_q;
    if (!filter_en_i)
    begin
      out_d = raw_i;
    end
    else if (hist_q == `TMWB_FILT_ONES)
    begin
      out_d = 1'b1; // [R12]
    end
    else if (hist_q == `TMWB_FILT_ZEROS)
    begin
      out_d = 1'b0; // [R12]
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      hist_q <= `TMWB_FILT_ZEROS;
      out_q  <= 1'b0;
    end
    else
    begin
      hist_q <= hist_d;
      out_q  <= out_d;
    end
  end

  assign filt_o = out_q;

  property p_filter_high;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (filter_en_i && raw_i)[*5] |=> out_q;
  endproperty
  a_filter_high: assert property (p_filter_high) else $error("filter output did not follow steady high input"); // [R12]

  property p_filter_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (filter_en_i && hist_q != `TMWB_FILT_ONES && hist_q != `TMWB_FILT_ZEROS) |=> $stable(out_q);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter output changed on mixed samples"); // [R12]
endmodule : tmwb_capture_filter

// >>> verification/tmwb_cpu_model.sv
// Processor core model driving the byte bus of the wide-access timer
`timescale 1ns/100ps
module tmwb_cpu_model
  import tmwb_pkg::*;
(
  // Clock
  input  wire logic                 clk_sys_i,
  // Byte bus
  input  wire tmwb_pkg::tmwb_byte_t cpu_rdata_i,
  output tmwb_pkg::tmwb_addr_t      cpu_addr_o,
  output logic                      cpu_wr_o,
  output logic                      cpu_rd_o,
  output tmwb_pkg::tmwb_byte_t      cpu_wdata_o
);
  import tmwb_pkg::*;

  initial
  begin
    cpu_addr_o  = 3'h0;
    cpu_wr_o    = 1'b0;
    cpu_rd_o    = 1'b0;
    cpu_wdata_o = 8'h00;
  end

  task wr_byte(input tmwb_addr_t a, input tmwb_byte_t d);
    @(posedge clk_sys_i);
    cpu_addr_o  <= a;
    cpu_wdata_o <= d;
    cpu_wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    cpu_wr_o    <= 1'b0;
    // Released data lines do not keep the last value
    cpu_wdata_o <= ~d;
    #1;
  endtask : wr_byte

  task rd_byte(input tmwb_addr_t a, output tmwb_byte_t d);
    @(posedge clk_sys_i);
    cpu_addr_o <= a;
    cpu_rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    cpu_rd_o   <= 1'b0;
    #1;
    d = cpu_rdata_i;
  endtask : rd_byte

  // High byte first, nothing else in between
  task wr_word(input tmwb_addr_t lo, input tmwb_word_t w);
    wr_byte(lo + 3'h1, w[15:8]);
    wr_byte(lo, w[7:0]);
  endtask : wr_word

  // Low byte first, nothing else in between
  task rd_word(input tmwb_addr_t lo, output tmwb_word_t w);
    tmwb_byte_t l;
    tmwb_byte_t h;
    rd_byte(lo, l);
    rd_byte(lo + 3'h1, h);
    w = {h, l};
  endtask : rd_word
endmodule : tmwb_cpu_model

// >>> verification/testbench.sv
// Self-checking bench for the wide-access timer block
`timescale 1ns/100ps
module testbench;
  import tmwb_pkg::*;
  logic       clk_sys_i;
  logic       rst_n_i;
  logic       count_en;
  logic       cap_src;
  logic       flag_clr;
  logic       cap_flag;
  logic       cpu_wr;
  logic       cpu_rd;
  tmwb_addr_t cpu_addr;
  tmwb_byte_t cpu_wdata;
  tmwb_byte_t cpu_rdata;
  tmwb_byte_t control_a;
  tmwb_word_t counter;
  tmwb_word_t compare;
  tmwb_byte_t b;
  tmwb_word_t w;
  int         n;
  int         n_fail;
  int         num_checks;
  int         cycles;

  tmwb_cpu_model cpu (.clk_sys_i(clk_sys_i), .cpu_rdata_i(cpu_rdata), .cpu_addr_o(cpu_addr),
    .cpu_wr_o(cpu_wr), .cpu_rd_o(cpu_rd), .cpu_wdata_o(cpu_wdata));

  tmwb_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_addr_i(cpu_addr), .cpu_wr_i(cpu_wr),
    .cpu_rd_i(cpu_rd), .cpu_wdata_i(cpu_wdata), .cpu_rdata_o(cpu_rdata), .count_en_i(count_en),
    .capture_src_i(cap_src), .capture_flag_clr_i(flag_clr), .capture_flag_o(cap_flag),
    .counter_o(counter), .compare_o(compare), .control_a_o(control_a));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task conclude;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task chk(input tmwb_word_t got, input tmwb_word_t exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Moves the capture source and counts edges until the flag rises
  task cap_wait(input logic lvl, output int k);
    @(posedge clk_sys_i);
    cap_src <= lvl;
    k = 0;
    while (cap_flag !== 1'b1 && k < 20)
    begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
  endtask : cap_wait

  // One-cycle pulse on the flag clear input
  task clr_flag;
    @(posedge clk_sys_i);
    flag_clr <= 1'b1;
    @(posedge clk_sys_i);
    flag_clr <= 1'b0;
    #1;
  endtask : clr_flag

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    rst_n_i  = 1'b0;
    count_en = 1'b0;
    cap_src  = 1'b0;
    flag_clr = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    chk({8'h00, control_a}, 16'h0000, "control reset");
    chk(counter | compare, 16'h0000, "word reset");
    cpu.wr_byte(3'h0, 8'hFF);
    cpu.rd_byte(3'h0, b);
    chk({8'h00, b}, 16'h00F9, "control mask");
    cpu.rd_byte(3'h5, b);
    chk({8'h00, b}, 16'h0000, "unmapped read");
    cpu.wr_byte(3'h0, 8'h80);
    cpu.wr_word(3'h1, 16'h01FF);
    chk(counter, 16'h01FF, "wide write");
    cpu.rd_word(3'h1, w);
    chk(w, 16'h01FF, "wide read");
    cpu.wr_byte(3'h2, 8'hAB);
    chk(counter, 16'h01FF, "high write to latch only");
    cpu.rd_byte(3'h2, b);
    chk({8'h00, b}, 16'h00AB, "high read gives latch");
    cpu.wr_byte(3'h2, 8'h12);
    cpu.wr_byte(3'h1, 8'h34);
    cpu.wr_byte(3'h3, 8'h56);
    chk(counter, 16'h1234, "shared high counter");
    chk(compare, 16'h1256, "shared high compare");
    cpu.wr_byte(3'h2, 8'hCD);
    cpu.rd_byte(3'h4, b);
    chk({8'h00, b}, 16'h0012, "compare high bypass");
    cpu.wr_word(3'h1, 16'h00FF);
    @(posedge clk_sys_i);
    count_en <= 1'b1;
    @(posedge clk_sys_i);
    count_en <= 1'b0;
    #1;
    chk(counter, 16'h0100, "wide count carry");
    cpu.wr_byte(3'h0, 8'hD0);
    cap_wait(1'b1, n);
    chk(n[15:0], 16'h0002, "rising capture delay");
    chk(compare, 16'h0100, "captured word");
    cpu.wr_byte(3'h2, 8'hCD);
    cpu.rd_byte(3'h4, b);
    chk({8'h00, b}, 16'h00CD, "capture high via latch");
    cpu.rd_word(3'h3, w);
    chk(w, 16'h0100, "capture word read");
    clr_flag();
    chk({15'h0000, cap_flag}, 16'h0000, "flag clear");
    cpu.wr_byte(3'h0, 8'hE0);
    cap_wait(1'b0, n);
    chk(n[15:0], 16'h0006, "filtered falling capture delay");
    cpu.wr_byte(3'h0, 8'h00);
    cpu.wr_byte(3'h2, 8'h5A);
    cpu.wr_byte(3'h1, 8'hFF);
    @(posedge clk_sys_i);
    count_en <= 1'b1;
    @(posedge clk_sys_i);
    count_en <= 1'b0;
    #1;
    chk(counter, 16'h5A00, "narrow count wraps low byte");
    cpu.wr_byte(3'h1, 8'h77);
    clr_flag();
    cpu.wr_byte(3'h0, 8'h70);
    cap_wait(1'b1, n);
    chk(n[15:0], 16'h0006, "filtered rising capture delay");
    chk(compare, 16'h0177, "narrow capture low byte");
    chk({15'h0000, cap_flag}, 16'h0001, "capture flag set");
    conclude();
  end
endmodule : testbench
